// ===== switch_control_defs.vh
// Overview of operation
// RULE_01: while reset_hold is one, hold all switch logic in reset except management slave.
// RULE_02: reset_hold zero lets switching run; later changes have no effect.
// RULE_03: eeprom initialization error, or eeprom contents, set reset_hold automatically.
// RULE_04: register_write_unlock one lets write_when_unlocked fields update, else read-only.
// RULE_05: register_write_unlock defaults zero but is set during reset operation.
// RULE_06: power_budget_value_unlock, itself lockable, makes power budget values writable.
// RULE_07: link_down_hot_reset_disable blocks only link-down hot resets.
// RULE_08: hot_reset_eeprom_load_skip omits eeprom load step during hot reset.
// RULE_09: relaxed_ordering_disable forces strong ordering of all transactions.
// RULE_10: peer_traffic_disable makes downstream non-upstream requests unsupported.
// RULE_11: cut_through_disable selects store-and-forward between all ports.
// RULE_12: locked_tlp_ignore drops lock side effects; locked requests route normally.
// RULE_13: sticky fields keep their values through hot reset.
// RULE_14: reserved bits 13:9 and 31:16 read zero and ignore writes.
`ifndef SWITCH_CONTROL_DEFS_VH
`define SWITCH_CONTROL_DEFS_VH
`define SWITCH_CONTROL_OFFSET   12'h404
`define BIT_RESET_HOLD          2
`define BIT_REG_UNLOCK          3
`define BIT_PB_UNLOCK           4
`define BIT_LD_HRST_DIS         5
`define BIT_HRST_EE_SKIP        6
`define BIT_RO_DIS              7
`define BIT_P2P_DIS             8
`define BIT_CT_DIS              14
`define BIT_LOCK_IGNORE         15
`define SWITCH_CONTROL_RW_MASK  32'h0000C1FC
`define SWITCH_CONTROL_RESET    32'h00000000
`endif

// ===== sync_bit.v
`timescale 1ns/10ps
module sync_bit (
    input  wire core_clk_in,
    input  wire rst_in,
    input  wire d_in,
    output wire q_out
);
    reg meta_r;
    reg q_r;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_r    <= meta_r;
        end
    end
    assign q_out = q_r;
endmodule

// ===== switch_control.v
`timescale 1ns/10ps
`include "switch_control_defs.vh"
module switch_control (
    input  wire        core_clk_in,
    input  wire        rst_in,
    input  wire        hot_reset_in,
    input  wire        reset_op_active_in,
    input  wire        reset_op_done_in,
    input  wire        eeprom_error_in,
    input  wire        eeprom_set_hold_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [11:0] reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        link_dl_down_in,
    input  wire        hot_reset_other_in,
    input  wire        ds_req_in,
    input  wire        ds_req_to_us_in,
    input  wire        tlp_ro_attr_in,
    input  wire        tlp_locked_in,
    output reg  [31:0] reg_rdata_out,
    output wire        switch_reset_out,
    output wire        hot_reset_start_out,
    output wire        hot_reset_eeprom_load_out,
    output wire        relaxed_ordering_out,
    output wire        unsupported_request_out,
    output wire        store_and_forward_out,
    output wire        lock_effects_out,
    output wire        write_when_unlocked_en_out,
    output wire        power_budget_value_wr_en_out
);
    localparam [31:0] RESET_VALUE = `SWITCH_CONTROL_RESET;

    // field flip-flops; every one of them is sticky across hot reset
    reg         reset_hold_r;
    reg         register_write_unlock_r;
    reg         power_budget_value_unlock_r;
    reg         link_down_hot_reset_disable_r;
    reg         hot_reset_eeprom_load_skip_r;
    reg         relaxed_ordering_disable_r;
    reg         peer_traffic_disable_r;
    reg         cut_through_disable_r;
    reg         locked_tlp_ignore_r;
    reg         hold_latched_r;

    // next values of the flip-flops above
    reg         reset_hold_nxt;
    reg         register_write_unlock_nxt;
    reg         power_budget_value_unlock_nxt;
    reg         link_down_hot_reset_disable_nxt;
    reg         hot_reset_eeprom_load_skip_nxt;
    reg         relaxed_ordering_disable_nxt;
    reg         peer_traffic_disable_nxt;
    reg         cut_through_disable_nxt;
    reg         locked_tlp_ignore_nxt;
    reg         hold_latched_nxt;
    reg  [31:0] rdata_nxt;
    reg  [31:0] rd_val;

    wire        dl_down_s;
    wire        wr_hit;
    wire        rd_hit;
    wire        eeprom_hold_req;

    // link state arrives from another clock domain
    sync_bit u_dl_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .d_in        (link_dl_down_in),
        .q_out       (dl_down_s)
    );

    assign wr_hit          = reg_wr_in && (reg_addr_in == `SWITCH_CONTROL_OFFSET);
    assign rd_hit          = reg_rd_in && (reg_addr_in == `SWITCH_CONTROL_OFFSET);
    assign eeprom_hold_req = eeprom_error_in || eeprom_set_hold_in;

    // a set request in the same cycle as a clearing write keeps the halt
    // RULE_03: eeprom sets hold
    always @* begin
        reset_hold_nxt = reset_hold_r;
        if (wr_hit) begin
            reset_hold_nxt = reg_wdata_in[`BIT_RESET_HOLD];
        end
        if (eeprom_hold_req) begin
            reset_hold_nxt = 1'h1;
        end
    end

    // reset sequencing overrides software so eeprom loading reaches locked fields
    // RULE_05: unlocked during reset
    always @* begin
        register_write_unlock_nxt = register_write_unlock_r;
        if (wr_hit) begin
            register_write_unlock_nxt = reg_wdata_in[`BIT_REG_UNLOCK];
        end
        if (reset_op_active_in) begin
            register_write_unlock_nxt = 1'h1;
        end
    end

    // the unlock bit is judged as it stood before the write
    // RULE_06: lockable budget unlock
    always @* begin
        power_budget_value_unlock_nxt = power_budget_value_unlock_r;
        if (wr_hit && register_write_unlock_r) begin
            power_budget_value_unlock_nxt = reg_wdata_in[`BIT_PB_UNLOCK];
        end
    end

    // plain read-write control fields
    always @* begin
        link_down_hot_reset_disable_nxt = link_down_hot_reset_disable_r;
        hot_reset_eeprom_load_skip_nxt  = hot_reset_eeprom_load_skip_r;
        relaxed_ordering_disable_nxt    = relaxed_ordering_disable_r;
        peer_traffic_disable_nxt        = peer_traffic_disable_r;
        cut_through_disable_nxt         = cut_through_disable_r;
        locked_tlp_ignore_nxt           = locked_tlp_ignore_r;
        if (wr_hit) begin
            link_down_hot_reset_disable_nxt = reg_wdata_in[`BIT_LD_HRST_DIS];
            hot_reset_eeprom_load_skip_nxt  = reg_wdata_in[`BIT_HRST_EE_SKIP];
            relaxed_ordering_disable_nxt    = reg_wdata_in[`BIT_RO_DIS];
            peer_traffic_disable_nxt        = reg_wdata_in[`BIT_P2P_DIS];
            cut_through_disable_nxt         = reg_wdata_in[`BIT_CT_DIS];
            locked_tlp_ignore_nxt           = reg_wdata_in[`BIT_LOCK_IGNORE];
        end
    end

    // the halt is decided when a reset operation completes; clearing
    // reset_hold then releases the switch, setting it later does nothing
    // RULE_02: halt release
    always @* begin
        hold_latched_nxt = hold_latched_r;
        if (reset_op_done_in) begin
            hold_latched_nxt = reset_hold_r;
        end else if (!reset_hold_r) begin
            hold_latched_nxt = 1'h0;
        end
    end

    // only rst_in returns the fields to their defaults; no hot reset input reaches here
    // RULE_13: sticky through hot reset
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            reset_hold_r                  <= RESET_VALUE[`BIT_RESET_HOLD];
            register_write_unlock_r       <= RESET_VALUE[`BIT_REG_UNLOCK];
            power_budget_value_unlock_r   <= RESET_VALUE[`BIT_PB_UNLOCK];
            link_down_hot_reset_disable_r <= RESET_VALUE[`BIT_LD_HRST_DIS];
            hot_reset_eeprom_load_skip_r  <= RESET_VALUE[`BIT_HRST_EE_SKIP];
            relaxed_ordering_disable_r    <= RESET_VALUE[`BIT_RO_DIS];
            peer_traffic_disable_r        <= RESET_VALUE[`BIT_P2P_DIS];
            cut_through_disable_r         <= RESET_VALUE[`BIT_CT_DIS];
            locked_tlp_ignore_r           <= RESET_VALUE[`BIT_LOCK_IGNORE];
            hold_latched_r                <= 1'h0;
        end else begin
            reset_hold_r                  <= reset_hold_nxt;
            register_write_unlock_r       <= register_write_unlock_nxt;
            power_budget_value_unlock_r   <= power_budget_value_unlock_nxt;
            link_down_hot_reset_disable_r <= link_down_hot_reset_disable_nxt;
            hot_reset_eeprom_load_skip_r  <= hot_reset_eeprom_load_skip_nxt;
            relaxed_ordering_disable_r    <= relaxed_ordering_disable_nxt;
            peer_traffic_disable_r        <= peer_traffic_disable_nxt;
            cut_through_disable_r         <= cut_through_disable_nxt;
            locked_tlp_ignore_r           <= locked_tlp_ignore_nxt;
            hold_latched_r                <= hold_latched_nxt;
        end
    end

    // control outputs toward the switch core

    // RULE_01: core held in reset
    assign switch_reset_out = hold_latched_r || reset_op_active_in;

    // RULE_04: lockable fields gated
    assign write_when_unlocked_en_out   = register_write_unlock_r;
    assign power_budget_value_wr_en_out = power_budget_value_unlock_r;

    // RULE_07: link-down cause masked
    assign hot_reset_start_out = hot_reset_in || hot_reset_other_in ||
                                 (dl_down_s && !link_down_hot_reset_disable_r);

    // RULE_08: eeprom step skipped
    assign hot_reset_eeprom_load_out = !hot_reset_eeprom_load_skip_r;

    // RULE_09: strong ordering override
    assign relaxed_ordering_out = tlp_ro_attr_in && !relaxed_ordering_disable_r;

    // RULE_10: peer requests refused
    assign unsupported_request_out = peer_traffic_disable_r && ds_req_in && !ds_req_to_us_in;

    // RULE_11: forwarding mode select
    assign store_and_forward_out = cut_through_disable_r;

    // RULE_12: lock semantics dropped
    assign lock_effects_out = tlp_locked_in && !locked_tlp_ignore_r;

    // the reset trigger bits 1:0 are handled outside this block and read zero
    // RULE_14: reserved bits zero
    always @* begin
        rd_val                      = 32'h00000000;
        rd_val[`BIT_RESET_HOLD]     = reset_hold_r;
        rd_val[`BIT_REG_UNLOCK]     = register_write_unlock_r;
        rd_val[`BIT_PB_UNLOCK]      = power_budget_value_unlock_r;
        rd_val[`BIT_LD_HRST_DIS]    = link_down_hot_reset_disable_r;
        rd_val[`BIT_HRST_EE_SKIP]   = hot_reset_eeprom_load_skip_r;
        rd_val[`BIT_RO_DIS]         = relaxed_ordering_disable_r;
        rd_val[`BIT_P2P_DIS]        = peer_traffic_disable_r;
        rd_val[`BIT_CT_DIS]         = cut_through_disable_r;
        rd_val[`BIT_LOCK_IGNORE]    = locked_tlp_ignore_r;
    end

    // unmatched addresses return zero; data stands until the next read
    always @* begin
        rdata_nxt = reg_rdata_out;
        if (rd_hit) begin
            rdata_nxt = rd_val & `SWITCH_CONTROL_RW_MASK;
        end else if (reg_rd_in) begin
            rdata_nxt = 32'h00000000;
        end
    end

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h00000000;
        end else begin
            reg_rdata_out <= rdata_nxt;
        end
    end
endmodule

// ===== switch_control_sva.sv
`timescale 1ns/10ps
module switch_control_sva (
    input wire        core_clk_in,
    input wire        rst_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [11:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire        hot_reset_in,
    input wire        reset_op_active_in,
    input wire        tlp_ro_attr_in,
    input wire [31:0] reg_rdata_out,
    input wire        switch_reset_out,
    input wire        hot_reset_start_out,
    input wire        relaxed_ordering_out,
    input wire        store_and_forward_out,
    input wire        write_when_unlocked_en_out,
    input wire        power_budget_value_wr_en_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence ctl_wr;
        reg_wr_in && reg_addr_in == 12'h404 && !reset_op_active_in;
    endsequence
    ct_follow_a: assert property (ctl_wr |=> store_and_forward_out == $past(reg_wdata_in[14]))
        else $error("cut-through bit wrong");
    unlock_wr_a: assert property (ctl_wr |=> write_when_unlocked_en_out == $past(reg_wdata_in[3]))
        else $error("unlock bit wrong");
    pb_lock_a: assert property (ctl_wr and !write_when_unlocked_en_out
        |=> $stable(power_budget_value_wr_en_out))
        else $error("locked field changed");
    ro_attr_a: assert property (relaxed_ordering_out |-> tlp_ro_attr_in)
        else $error("relaxed order without attribute");
    op_hold_a: assert property (reset_op_active_in |-> switch_reset_out)
        else $error("switch not held in reset");
    hot_cause_a: assert property (hot_reset_in |-> hot_reset_start_out)
        else $error("hot reset cause lost");
    resv_zero_a: assert property (reg_rd_in |=> (reg_rdata_out & 32'hFFFF3E03) == 32'h0)
        else $error("reserved bits nonzero");
    op_unlock_a: assert property (reset_op_active_in ##1 reset_op_active_in |-> write_when_unlocked_en_out)
        else $error("unlock not set in reset");
endmodule

// ===== switch_control_bench.sv
`timescale 1ns/10ps
module switch_control_bench;
    reg clk = 0, rst = 1, hr = 0, act = 0, done = 0, eer = 0, wr = 0, rd = 0, dld = 0;
    reg ds = 0, tus = 0, ro = 0, lk = 0, esh = 0, hro = 0;
    reg [11:0] ad = 12'h404;
    reg [31:0] wd = 0;
    wire [31:0] q;
    wire sr, hs, el, rx, ur, sf, le, wu, pb;
    integer mismatches = 0, n_tests = 0, cyc = 0, ctl = 0, i;
    switch_control u_dut (.core_clk_in(clk), .rst_in(rst), .hot_reset_in(hr),
        .reset_op_active_in(act), .reset_op_done_in(done), .eeprom_error_in(eer),
        .eeprom_set_hold_in(esh), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(ad),
        .reg_wdata_in(wd), .link_dl_down_in(dld), .hot_reset_other_in(hro), .ds_req_in(ds),
        .ds_req_to_us_in(tus), .tlp_ro_attr_in(ro), .tlp_locked_in(lk), .reg_rdata_out(q),
        .switch_reset_out(sr), .hot_reset_start_out(hs), .hot_reset_eeprom_load_out(el),
        .relaxed_ordering_out(rx), .unsupported_request_out(ur), .store_and_forward_out(sf),
        .lock_effects_out(le), .write_when_unlocked_en_out(wu), .power_budget_value_wr_en_out(pb));
    always #5 clk = ~clk;
    task conclude;
        begin
            $display("mismatches %0d n_tests %0d", mismatches, n_tests);
            if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 1000) begin
            $display("unexpected at %0t: timeout", $time);
            mismatches = mismatches + 1;
            conclude;
        end
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task tk;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task wrt(input [31:0] d);
        begin
            wd = d;
            wr = 1;
            tk;
            wr = 0;
            ctl = (d & 32'hC1EC) | ((ctl[3] ? d : ctl) & 32'h10);
        end
    endtask
    task rdc(input [31:0] e);
        begin
            rd = 1;
            tk;
            rd = 0;
            chk(q, e);
        end
    endtask
    initial begin
        i = $urandom(32'hE32A129E);
        repeat (5) tk;
        rst = 0;
        rdc(32'h0);
        for (i = 0; i < 12; i = i + 1) begin
            {ds, tus, ro, lk} = $urandom;
            wrt($urandom);
            chk(wu, ctl[3]);
            chk(pb, ctl[4]);
            chk(el, !ctl[6]);
            chk(rx, ro & !ctl[7]);
            chk(ur, ctl[8] & ds & !tus);
            chk(sf, ctl[14]);
            chk(le, lk & !ctl[15]);
            rdc(ctl);
        end
        ad = 12'h408;
        rdc(32'h0);
        ad = 12'h404;
        wrt(32'h4);
        done = 1;
        tk;
        done = 0;
        chk(sr, 1);
        wrt(32'h0);
        chk(sr, 1);
        tk;
        chk(sr, 0);
        wrt(32'h4);
        tk;
        chk(sr, 0);
        esh = 1;
        wrt(32'h0);
        esh = 0;
        ctl = ctl | 4;
        rdc(ctl);
        wrt(32'h0);
        eer = 1;
        tk;
        eer = 0;
        ctl = ctl | 4;
        rdc(ctl);
        act = 1;
        repeat (2) tk;
        act = 0;
        chk(wu, 1);
        ctl = ctl | 8;
        hr = 1;
        tk;
        hr = 0;
        rdc(ctl);
        wrt(32'h20);
        dld = 1;
        repeat (3) tk;
        chk(hs, 0);
        hro = 1;
        tk;
        chk(hs, 1);
        hro = 0;
        wrt(32'h0);
        chk(hs, 1);
        conclude;
    end
endmodule
bind switch_control switch_control_sva u_sva (.core_clk_in, .rst_in, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in, .hot_reset_in, .reset_op_active_in, .tlp_ro_attr_in,
    .reg_rdata_out, .switch_reset_out, .hot_reset_start_out, .relaxed_ordering_out,
    .store_and_forward_out, .write_when_unlocked_en_out, .power_budget_value_wr_en_out);
